// [hdl/cpu_exec_pkg.sv]
// Shared constants, types and decode helpers for the 8-bit core execution block.
// Assumes a single clock domain and an asynchronous-read byte memory outside the core.
package cpu_exec_pkg;

	localparam logic [7:0] OP_TRAP = 8'h83;
	localparam logic [7:0] OP_ACC_TO_FLAGS = 8'h84;
	localparam logic [7:0] OP_FLAGS_TO_ACC = 8'h85;
	localparam logic [7:0] OP_ACC_TO_XLOW = 8'h97;
	localparam logic [7:0] OP_XLOW_TO_ACC = 8'h9f;
	localparam logic [7:0] OP_STACK_TO_INDEX = 8'h95;
	localparam logic [7:0] OP_INDEX_TO_STACK = 8'h94;
	localparam logic [7:0] OP_WAIT = 8'h8f;
	localparam logic [7:0] OP_PREFIX = 8'h9e;
	localparam logic [7:0] OP_TEST_PAGE = 8'h3d;
	localparam logic [7:0] OP_TEST_ACC = 8'h4d;
	localparam logic [7:0] OP_TEST_XLOW = 8'h5d;
	localparam logic [7:0] OP_TEST_IDX_BYTE = 8'h6d;
	localparam logic [7:0] OP_TEST_IDX_PLAIN = 8'h7d;
	localparam logic [7:0] OP_LOAD_LONG = 8'hc6;
	localparam logic [7:0] OP_LOAD_IDX_WORD = 8'hd6;
	localparam logic [7:0] OP_LOAD_IDX_BYTE = 8'he6;
	localparam logic [7:0] OP_LOAD_IDX_PLAIN = 8'hf6;
	localparam logic [7:0] OP_MOVE_PAGE_PAGE = 8'h4e;
	localparam logic [7:0] OP_MOVE_PAGE_IDX = 8'h5e;
	localparam logic [7:0] OP_MOVE_LIT_PAGE = 8'h6e;
	localparam logic [7:0] OP_MOVE_IDX_PAGE = 8'h7e;

	localparam int unsigned FLAG_V = 7;
	localparam int unsigned FLAG_I = 3;
	localparam int unsigned FLAG_N = 2;
	localparam int unsigned FLAG_Z = 1;
	localparam int unsigned FLAG_C = 0;

	localparam logic [15:0] RESET_PC = 16'h0000;
	localparam logic [15:0] RESET_SP = 16'h00ff;
	localparam logic [7:0] RESET_FLAGS = 8'h68;
	localparam logic [15:0] TRAP_VEC_HI_ADDR = 16'hfffc;
	localparam logic [15:0] TRAP_VEC_LO_ADDR = 16'hfffd;
	localparam logic [2:0] PUSH_LAST = 3'd4;
	localparam logic [15:0] ONE_16 = 16'h0001;

	typedef enum logic [3:0] {
		MODE_IMPLIED, MODE_PAGE, MODE_LONG_ABS, MODE_PLAIN_INDEX, MODE_INDEX_BYTE,
		MODE_INDEX_WORD, MODE_STACK_BYTE, MODE_STACK_WORD, MODE_PAGE_PAGE,
		MODE_PAGE_TO_INDEXED, MODE_INDEXED_TO_PAGE, MODE_LITERAL_TO_PAGE, MODE_BIT_BRANCH
	} addr_mode_t;

	typedef enum logic [2:0] {
		KIND_NONE, KIND_TEST, KIND_LOAD, KIND_MOVE, KIND_BIT_BRANCH
	} op_kind_t;

	typedef enum logic [11:0] {
		ST_FETCH = 12'h001,
		ST_PREFIX = 12'h002,
		ST_OPND1 = 12'h004,
		ST_OPND2 = 12'h008,
		ST_READ = 12'h010,
		ST_WRITE = 12'h020,
		ST_INTERNAL = 12'h040,
		ST_TRAP_INC = 12'h080,
		ST_PUSH = 12'h100,
		ST_VEC_HI = 12'h200,
		ST_VEC_LO = 12'h400,
		ST_HALT = 12'h800
	} core_state_t;

	function automatic addr_mode_t decode_mode(input logic pre, input logic [7:0] op);
		addr_mode_t m;
		m = MODE_IMPLIED;
		if (pre) begin
			if (op == OP_TEST_IDX_BYTE || op == OP_LOAD_IDX_BYTE) m = MODE_STACK_BYTE;
			else if (op == OP_LOAD_IDX_WORD) m = MODE_STACK_WORD;
		end else if (op[7:4] == 4'h0) begin
			m = MODE_BIT_BRANCH;
		end else begin
			case (op)
				OP_TEST_PAGE: m = MODE_PAGE;
				OP_TEST_IDX_BYTE, OP_LOAD_IDX_BYTE: m = MODE_INDEX_BYTE;
				OP_TEST_IDX_PLAIN, OP_LOAD_IDX_PLAIN: m = MODE_PLAIN_INDEX;
				OP_LOAD_LONG: m = MODE_LONG_ABS;
				OP_LOAD_IDX_WORD: m = MODE_INDEX_WORD;
				OP_MOVE_PAGE_PAGE: m = MODE_PAGE_PAGE;
				OP_MOVE_PAGE_IDX: m = MODE_PAGE_TO_INDEXED;
				OP_MOVE_LIT_PAGE: m = MODE_LITERAL_TO_PAGE;
				OP_MOVE_IDX_PAGE: m = MODE_INDEXED_TO_PAGE;
				default: m = MODE_IMPLIED;
			endcase
		end
		return m;
	endfunction

	function automatic op_kind_t decode_kind(input logic pre, input logic [7:0] op);
		op_kind_t k;
		k = KIND_NONE;
		if (pre) begin
			if (op == OP_TEST_IDX_BYTE) k = KIND_TEST;
			else if (op == OP_LOAD_IDX_BYTE || op == OP_LOAD_IDX_WORD) k = KIND_LOAD;
		end else if (op[7:4] == 4'h0) begin
			k = KIND_BIT_BRANCH;
		end else begin
			case (op)
				OP_TEST_PAGE, OP_TEST_IDX_BYTE, OP_TEST_IDX_PLAIN: k = KIND_TEST;
				OP_LOAD_LONG, OP_LOAD_IDX_WORD, OP_LOAD_IDX_BYTE, OP_LOAD_IDX_PLAIN: k = KIND_LOAD;
				OP_MOVE_PAGE_PAGE, OP_MOVE_PAGE_IDX, OP_MOVE_LIT_PAGE, OP_MOVE_IDX_PAGE: k = KIND_MOVE;
				default: k = KIND_NONE;
			endcase
		end
		return k;
	endfunction

	function automatic logic [1:0] operand_bytes(input addr_mode_t m);
		case (m)
			MODE_PAGE, MODE_INDEX_BYTE, MODE_STACK_BYTE, MODE_PAGE_TO_INDEXED,
			MODE_INDEXED_TO_PAGE: return 2'd1;
			MODE_LONG_ABS, MODE_INDEX_WORD, MODE_STACK_WORD, MODE_PAGE_PAGE,
			MODE_LITERAL_TO_PAGE, MODE_BIT_BRANCH: return 2'd2;
			default: return 2'd0;
		endcase
	endfunction

endpackage

// [hdl/cpu_transfer_test_trap_exec.sv]
// Execution sequencer for trap, register transfer, test, wait and the operand modes.
// Assumes a byte memory whose read data answers the presented address in the same cycle.
`timescale 1ns/1ps
module cpu_transfer_test_trap_exec (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic irq_i,
	input wire logic [7:0] mem_rdata_i,
	output logic [15:0] mem_addr_o,
	output logic [7:0] mem_wdata_o,
	output logic mem_rd_o,
	output logic mem_wr_o,
	output logic core_clk_run_o,
	output logic unknown_op_o,
	output logic [7:0] acc_o,
	output logic [15:0] index_o,
	output logic [15:0] stack_o,
	output logic [15:0] pc_o,
	output logic [7:0] flags_o
);
	import cpu_exec_pkg::*;

	typedef struct packed {
		core_state_t st;
		logic [15:0] pc;
		logic [15:0] sp;
		logic [15:0] hx;
		logic [7:0] acc;
		logic [7:0] flags;
		logic [7:0] op;
		addr_mode_t mode;
		op_kind_t kind;
		logic [7:0] b1;
		logic [7:0] b2;
		logic [15:0] ea;
		logic [7:0] mdata;
		logic [2:0] push_idx;
		logic [15:0] addr;
		logic [7:0] wdata;
		logic rd;
		logic wr;
		logic unknown;
	} core_regs_t;

	core_regs_t r;
	core_regs_t n;
	addr_mode_t dec_mode;
	op_kind_t dec_kind;
	addr_mode_t ea_mode;
	logic launching;
	logic [7:0] ea_b1;
	logic [7:0] ea_b2;
	logic [15:0] ea_w;

	function automatic logic [7:0] nz_update(input logic [7:0] f, input logic [7:0] d);
		logic [7:0] o;
		o = f;
		o[FLAG_V] = 1'b0;
		o[FLAG_N] = d[7];
		o[FLAG_Z] = (d == 8'h00);
		return o;
	endfunction

	assign dec_mode = decode_mode(r.st == ST_PREFIX, mem_rdata_i);
	assign dec_kind = decode_kind(r.st == ST_PREFIX, mem_rdata_i);
	assign launching = (r.st == ST_FETCH) || (r.st == ST_PREFIX);
	assign ea_mode = launching ? dec_mode : r.mode;
	// Offset bytes are taken straight off the bus so the read can follow without a gap
	assign ea_b1 = (r.st == ST_OPND1) ? mem_rdata_i : r.b1;
	assign ea_b2 = (r.st == ST_OPND2) ? mem_rdata_i : r.b2;

	operand_addr_calc u_addr (
		.mode_i(ea_mode),
		.first_byte_i(ea_b1),
		.second_byte_i(ea_b2),
		.stack_i(r.sp),
		.index_i(r.hx),
		.addr_o(ea_w)
	);

	always_comb begin
		logic do_launch;
		logic last_opnd;
		logic bit_val;
		do_launch = 1'b0;
		last_opnd = 1'b0;
		bit_val = 1'b0;
		n = r;
		n.unknown = 1'b0;
		unique case (r.st)
			ST_FETCH: begin
				n.pc = r.pc + ONE_16;
				n.op = mem_rdata_i;
				case (mem_rdata_i)
					OP_PREFIX: n.st = ST_PREFIX;
					OP_TRAP: n.st = ST_TRAP_INC;
					OP_ACC_TO_FLAGS, OP_STACK_TO_INDEX, OP_INDEX_TO_STACK: n.st = ST_INTERNAL;
					OP_FLAGS_TO_ACC: n.acc = r.flags;
					OP_ACC_TO_XLOW: n.hx[7:0] = r.acc;
					OP_XLOW_TO_ACC: n.acc = r.hx[7:0];
					OP_TEST_ACC: n.flags = nz_update(r.flags, r.acc);
					OP_TEST_XLOW: n.flags = nz_update(r.flags, r.hx[7:0]);
					OP_WAIT: begin
						n.flags[FLAG_I] = 1'b0;
						n.st = ST_HALT;
					end
					default: do_launch = 1'b1;
				endcase
			end
			ST_PREFIX: begin
				n.pc = r.pc + ONE_16;
				n.op = mem_rdata_i;
				n.st = ST_FETCH;
				do_launch = 1'b1;
			end
			ST_OPND1: begin
				// Operand bytes come in stream order: high before low, page byte before offset
				n.pc = r.pc + ONE_16;
				n.b1 = mem_rdata_i;
				if (operand_bytes(r.mode) == 2'd2) n.st = ST_OPND2;
				else last_opnd = 1'b1;
			end
			ST_OPND2: begin
				n.pc = r.pc + ONE_16;
				n.b2 = mem_rdata_i;
				last_opnd = 1'b1;
			end
			ST_READ: begin
				unique case (r.kind)
					KIND_TEST: begin
						n.flags = nz_update(r.flags, mem_rdata_i);
						n.st = ST_FETCH;
					end
					KIND_MOVE: begin
						n.mdata = mem_rdata_i;
						n.flags = nz_update(r.flags, mem_rdata_i);
						n.st = ST_WRITE;
						if (r.mode == MODE_PAGE_PAGE) n.ea = {8'h00, r.b2};
						else if (r.mode == MODE_PAGE_TO_INDEXED) n.ea = r.hx;
						else n.ea = {8'h00, r.b1};
					end
					KIND_BIT_BRANCH: begin
						bit_val = mem_rdata_i[r.op[3:1]];
						n.flags[FLAG_C] = bit_val;
						if (bit_val ^ r.op[0]) n.pc = r.pc + {{8{r.b2[7]}}, r.b2};
						n.st = ST_INTERNAL;
					end
					default: begin
						n.acc = mem_rdata_i;
						n.flags = nz_update(r.flags, mem_rdata_i);
						n.st = ST_FETCH;
					end
				endcase
			end
			ST_WRITE: begin
				// Index steps only once the byte has gone out
				if (r.mode == MODE_PAGE_TO_INDEXED || r.mode == MODE_INDEXED_TO_PAGE)
					n.hx = r.hx + ONE_16;
				n.st = ST_FETCH;
			end
			ST_INTERNAL: begin
				if (r.op == OP_ACC_TO_FLAGS) n.flags = r.acc;
				else if (r.op == OP_STACK_TO_INDEX) n.hx = r.sp + ONE_16;
				else if (r.op == OP_INDEX_TO_STACK) n.sp = r.hx - ONE_16;
				n.st = ST_FETCH;
			end
			ST_TRAP_INC: begin
				// PC already points past the opcode; this cycle spaces the sequence and zeroes the push counter
				n.push_idx = 3'd0;
				n.st = ST_PUSH;
			end
			ST_PUSH: begin
				n.sp = r.sp - ONE_16;
				n.push_idx = r.push_idx + 3'd1;
				if (r.push_idx == PUSH_LAST) begin
					n.flags[FLAG_I] = 1'b1;
					n.st = ST_VEC_HI;
				end
			end
			ST_VEC_HI: begin
				n.pc[15:8] = mem_rdata_i;
				n.st = ST_VEC_LO;
			end
			ST_VEC_LO: begin
				n.pc[7:0] = mem_rdata_i;
				n.st = ST_FETCH;
			end
			ST_HALT: begin
				// Nothing but the wake-up moves while stopped
				if (irq_i) n.st = ST_FETCH;
			end
		endcase

		if (do_launch) begin
			if (dec_kind == KIND_NONE) begin
				n.unknown = 1'b1;
				n.st = ST_FETCH;
			end else begin
				n.mode = dec_mode;
				n.kind = dec_kind;
				if (operand_bytes(dec_mode) == 2'd0) begin
					n.ea = ea_w;
					n.st = ST_READ;
				end else begin
					n.st = ST_OPND1;
				end
			end
		end
		if (last_opnd) begin
			n.ea = ea_w;
			if (r.mode == MODE_LITERAL_TO_PAGE) begin
				n.mdata = r.b1;
				// No read cycle here, so the moved byte sets the flags straight from the stream
				n.flags = nz_update(r.flags, r.b1);
				n.st = ST_WRITE;
			end else begin
				n.st = ST_READ;
			end
		end

		n.addr = n.pc;
		n.rd = 1'b1;
		n.wr = 1'b0;
		n.wdata = 8'h00;
		unique case (n.st)
			ST_READ: n.addr = n.ea;
			ST_WRITE: begin
				n.addr = n.ea;
				n.rd = 1'b0;
				n.wr = 1'b1;
				n.wdata = n.mdata;
			end
			ST_PUSH: begin
				n.addr = n.sp;
				n.rd = 1'b0;
				n.wr = 1'b1;
				case (n.push_idx)
					3'd0: n.wdata = n.pc[7:0];
					3'd1: n.wdata = n.pc[15:8];
					3'd2: n.wdata = n.hx[7:0];
					3'd3: n.wdata = n.acc;
					default: n.wdata = n.flags;
				endcase
			end
			ST_VEC_HI: n.addr = TRAP_VEC_HI_ADDR;
			ST_VEC_LO: n.addr = TRAP_VEC_LO_ADDR;
			ST_TRAP_INC, ST_INTERNAL, ST_HALT: n.rd = 1'b0;
			default: n.rd = 1'b1;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			r <= '0;
			r.st <= ST_FETCH;
			r.pc <= RESET_PC;
			r.sp <= RESET_SP;
			r.flags <= RESET_FLAGS;
			r.mode <= MODE_IMPLIED;
			r.kind <= KIND_NONE;
			r.addr <= RESET_PC;
			r.rd <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign mem_addr_o = r.addr;
	assign mem_wdata_o = r.wdata;
	assign mem_rd_o = r.rd;
	assign mem_wr_o = r.wr;
	assign core_clk_run_o = (r.st != ST_HALT);
	assign unknown_op_o = r.unknown;
	assign acc_o = r.acc;
	assign index_o = r.hx;
	assign stack_o = r.sp;
	assign pc_o = r.pc;
	assign flags_o = r.flags;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_trap_nine_cycles: assert property (
		// Sampled reset keeps the release edge, still a reset edge, from starting an attempt
		(rst_n_i && r.st == ST_FETCH && mem_rdata_i == OP_TRAP) |-> ##9 (r.st == ST_FETCH && r.flags[FLAG_I]))
		else $error("trap did not finish in nine cycles");
	a_trap_push_sp: assert property (
		(r.st == ST_PUSH) |=> (r.sp == 16'($past(r.sp) - ONE_16)) && mem_wr_o || (r.st == ST_VEC_HI))
		else $error("stack pointer not decremented on push");
	a_trap_mask_set: assert property (
		(r.st == ST_VEC_HI) |-> r.flags[FLAG_I] && mem_addr_o == TRAP_VEC_HI_ADDR)
		else $error("mask not set before vector fetch");
	a_test_flags: assert property (
		(r.st == ST_FETCH && mem_rdata_i == OP_TEST_ACC) |=>
			!r.flags[FLAG_V] && r.flags[FLAG_Z] == ($past(r.acc) == 8'h00) && $stable(r.flags[FLAG_C]))
		else $error("test flags wrong");
	a_wait_clears_mask: assert property (
		(r.st == ST_FETCH && mem_rdata_i == OP_WAIT) |=> !r.flags[FLAG_I] && !core_clk_run_o)
		else $error("wait did not clear mask and halt");
	a_halt_holds: assert property (
		(r.st == ST_HALT && !irq_i) |=> (r.st == ST_HALT) && $stable(r.pc) && $stable(r.sp))
		else $error("core moved while halted");
	a_copy_keeps_flags: assert property (
		(r.st == ST_FETCH && mem_rdata_i == OP_ACC_TO_XLOW) |=>
			r.hx[7:0] == $past(r.acc) && $stable(r.flags) && r.st == ST_FETCH)
		else $error("accumulator copy wrong");
	a_flags_load: assert property (
		(r.st == ST_FETCH && mem_rdata_i == OP_ACC_TO_FLAGS) |-> ##2 r.flags == $past(r.acc, 2))
		else $error("flag register not loaded");
	a_stack_to_index: assert property (
		(r.st == ST_FETCH && mem_rdata_i == OP_STACK_TO_INDEX) |-> ##2
			(r.hx == 16'($past(r.sp, 2) + ONE_16)) && r.st == ST_FETCH)
		else $error("index not stack plus one");
	a_move_post_inc: assert property (
		(r.st == ST_WRITE && r.mode == MODE_PAGE_TO_INDEXED) |->
			mem_addr_o == r.hx ##1 r.hx == 16'($past(r.hx) + ONE_16))
		else $error("post increment missing");

endmodule

// [hdl/operand_addr_calc.sv]
// Operand location former for every memory addressing mode of the core.
// Purely combinational; fed with the offset bytes as they arrive from memory.
`timescale 1ns/1ps
module operand_addr_calc (
	input wire cpu_exec_pkg::addr_mode_t mode_i,
	input wire logic [7:0] first_byte_i,
	input wire logic [7:0] second_byte_i,
	input wire logic [15:0] stack_i,
	input wire logic [15:0] index_i,
	output logic [15:0] addr_o
);
	import cpu_exec_pkg::*;

	always_comb begin
		unique case (mode_i)
			MODE_PAGE, MODE_PAGE_PAGE, MODE_PAGE_TO_INDEXED, MODE_BIT_BRANCH:
				addr_o = {8'h00, first_byte_i};
			MODE_LONG_ABS: addr_o = {first_byte_i, second_byte_i};
			MODE_PLAIN_INDEX, MODE_INDEXED_TO_PAGE: addr_o = index_i;
			MODE_INDEX_BYTE: addr_o = index_i + {8'h00, first_byte_i};
			MODE_INDEX_WORD: addr_o = index_i + {first_byte_i, second_byte_i};
			MODE_STACK_BYTE: addr_o = stack_i + {8'h00, first_byte_i};
			MODE_STACK_WORD: addr_o = stack_i + {first_byte_i, second_byte_i};
			MODE_LITERAL_TO_PAGE: addr_o = {8'h00, second_byte_i};
			default: addr_o = index_i;
		endcase
	end

endmodule

// [testbench/tb_top.sv]
// Self-checking bench: builds a program with a reference model, then compares the core at every fetch.
// Assumes the core reads a zero-wait byte memory, modelled here as an array answering combinationally.
`timescale 1ns/1ps
module tb_top;
	import cpu_exec_pkg::*;
	typedef struct {logic [15:0] pc; int cyc; bit wt; logic [7:0] a; logic [15:0] x; logic [15:0] s;
		logic [7:0] f; bit u;} step_t;
	logic sys_clk_i, rst_n_i, irq_i;
	logic [7:0] mem_rdata_i, mem_wdata_o, acc_o, flags_o;
	logic [15:0] mem_addr_o, index_o, stack_o, pc_o;
	logic mem_rd_o, mem_wr_o, core_clk_run_o, unknown_op_o;
	logic [7:0] mem [0:65535];
	logic [7:0] mm [0:65535];
	logic [7:0] ma, mf;
	logic [15:0] mx, ms, g;
	step_t q[$];
	logic [15:0] wq[$];
	int err_total, checks, seed;
	bit mu;

	cpu_transfer_test_trap_exec uut (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .irq_i(irq_i), .mem_rdata_i(mem_rdata_i),
		.mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
		.core_clk_run_o(core_clk_run_o), .unknown_op_o(unknown_op_o), .acc_o(acc_o), .index_o(index_o),
		.stack_o(stack_o), .pc_o(pc_o), .flags_o(flags_o)
	);

	assign mem_rdata_i = mem[mem_addr_o];
	always @(posedge sys_clk_i) begin
		if (mem_wr_o === 1'b1) mem[mem_addr_o] <= mem_wdata_o;
	end

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	task automatic print_verdict();
		if (err_total == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [7:0] rnd();
		return 8'($random(seed));
	endfunction

	// Program bytes go to both memories; the model memory alone receives the expected writes
	task automatic pb(input int n, input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
		input logic [7:0] b3);
		logic [7:0] bs [4];
		bs = '{b0, b1, b2, b3};
		for (int i = 0; i < n; i++) begin
			mem[g] = bs[i];
			mm[g] = bs[i];
			g++;
		end
	endtask

	task automatic da(input logic [15:0] ad, input logic [7:0] v);
		mem[ad] = v;
		mm[ad] = v;
	endtask

	task automatic step(input int cyc, input bit wt);
		q.push_back('{g, cyc, wt, ma, mx, ms, mf, mu});
	endtask

	task automatic nz(input logic [7:0] v);
		mf[FLAG_V] = 1'b0;
		mf[FLAG_N] = v[7];
		mf[FLAG_Z] = (v == 8'h00);
	endtask

	task automatic wr(input logic [15:0] ad, input logic [7:0] v);
		mm[ad] = v;
		wq.push_back(ad);
	endtask

	task automatic ld(input logic [15:0] ad, input logic [7:0] v, input int cyc);
		da(ad, v);
		ma = v;
		nz(v);
		step(cyc, 0);
	endtask

	// Every data address is placed once only, since the memory image is fixed before the run
	task automatic tz(input logic [15:0] ad, input logic [7:0] v, input int cyc);
		da(ad, v);
		nz(v);
		step(cyc, 0);
	endtask

	task automatic mv(input logic [15:0] ad, input logic [7:0] v, input logic [15:0] inc, input int cyc);
		wr(ad, v);
		nz(v);
		mx = mx + inc;
		step(cyc, 0);
	endtask

	initial begin
		logic [7:0] v, b;
		logic [15:0] o;
		seed = 32'h71b300c0;
		err_total = 0;
		checks = 0;
		rst_n_i = 1'b0;
		irq_i = 1'b0;
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'h00;
			mm[i] = 8'h00;
		end
		ma = 8'h00;
		mx = 16'h0000;
		ms = RESET_SP;
		mf = RESET_FLAGS;
		g = RESET_PC;
		step(0, 0);
		da(TRAP_VEC_HI_ADDR, 8'h04);
		da(TRAP_VEC_LO_ADDR, 8'h00);
		pb(1, OP_TRAP, 8'h00, 8'h00, 8'h00);
		wr(ms, g[7:0]);
		wr(ms - 16'h1, g[15:8]);
		wr(ms - 16'h2, mx[7:0]);
		wr(ms - 16'h3, ma);
		wr(ms - 16'h4, mf);
		ms = ms - 16'h5;
		mf[FLAG_I] = 1'b1;
		g = 16'h0400;
		step(9, 0);
		pb(3, OP_LOAD_LONG, 8'h30, 8'h00, 8'h00);
		ld(16'h3000, 8'h60, 4);
		pb(1, OP_ACC_TO_XLOW, 8'h00, 8'h00, 8'h00);
		mx = {mx[15:8], ma};
		step(1, 0);
		o = 16'h1000 | 16'(rnd());
		pb(3, OP_LOAD_IDX_WORD, o[15:8], o[7:0], 8'h00);
		ld(mx + o, rnd(), 4);
		b = 8'h20 | (rnd() & 8'h1f);
		pb(2, OP_LOAD_IDX_BYTE, b, 8'h00, 8'h00);
		ld(mx + b, rnd(), 3);
		pb(1, OP_LOAD_IDX_PLAIN, 8'h00, 8'h00, 8'h00);
		ld(mx, rnd(), 2);
		o = 16'h2000 | 16'(rnd());
		pb(4, OP_PREFIX, OP_LOAD_IDX_WORD, o[15:8], o[7:0]);
		ld(ms + o, rnd(), 5);
		b = 8'h40 | (rnd() & 8'h1f);
		pb(3, OP_PREFIX, OP_LOAD_IDX_BYTE, b, 8'h00);
		ld(ms + b, rnd(), 4);
		pb(1, OP_TEST_IDX_PLAIN, 8'h00, 8'h00, 8'h00);
		nz(mm[mx]);
		step(2, 0);
		// Zero and negative operands come first so both flag outcomes are seen
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : rnd();
			pb(3, OP_LOAD_LONG, 8'h31, 8'(i), 8'h00);
			ld({8'h31, 8'(i)}, rnd(), 4);
			pb(1, OP_ACC_TO_FLAGS, 8'h00, 8'h00, 8'h00);
			mf = ma;
			step(2, 0);
			pb(1, OP_FLAGS_TO_ACC, 8'h00, 8'h00, 8'h00);
			ma = mf;
			step(1, 0);
			pb(1, OP_TEST_ACC, 8'h00, 8'h00, 8'h00);
			nz(ma);
			step(1, 0);
			pb(1, OP_TEST_XLOW, 8'h00, 8'h00, 8'h00);
			nz(mx[7:0]);
			step(1, 0);
			pb(2, OP_TEST_PAGE, 8'h50 + 8'(i), 8'h00, 8'h00);
			tz(16'h0050 + 16'(i), v, 3);
			pb(2, OP_TEST_IDX_BYTE, 8'hc0 + 8'(i), 8'h00, 8'h00);
			tz(mx + 16'h00c0 + 16'(i), ~v, 3);
			pb(3, OP_PREFIX, OP_TEST_IDX_BYTE, 8'h30 + 8'(i), 8'h00);
			tz(ms + 16'h0030 + 16'(i), v, 4);
		end
		da(16'h0058, rnd());
		pb(3, OP_MOVE_PAGE_PAGE, 8'h58, 8'h59, 8'h00);
		mv(16'h0059, mm[16'h0058], 16'h0, 5);
		da(16'h005a, rnd());
		pb(2, OP_MOVE_PAGE_IDX, 8'h5a, 8'h00, 8'h00);
		mv(mx, mm[16'h005a], 16'h1, 4);
		b = rnd();
		pb(3, OP_MOVE_LIT_PAGE, b, 8'h5b, 8'h00);
		mv(16'h005b, b, 16'h0, 4);
		da(mx, rnd());
		pb(2, OP_MOVE_IDX_PAGE, 8'h5c, 8'h00, 8'h00);
		mv(16'h005c, mm[mx], 16'h1, 4);
		// Odd opcodes branch on a clear bit; a branch not taken runs the two filler no-ops
		for (int i = 0; i < 16; i++) begin
			b = rnd();
			da(16'h0040 + 16'(i), b);
			pb(3, 8'(i), 8'h40 + 8'(i), 8'h02, 8'h00);
			mf[FLAG_C] = b[i / 2];
			if (b[i / 2] ^ i[0]) begin
				pb(2, 8'h9d, 8'h9d, 8'h00, 8'h00);
				step(5, 0);
			end else begin
				step(5, 0);
				mu = 1'b1;
				pb(1, 8'h9d, 8'h00, 8'h00, 8'h00);
				step(1, 0);
				pb(1, 8'h9d, 8'h00, 8'h00, 8'h00);
				step(1, 0);
				mu = 1'b0;
			end
		end
		pb(3, OP_LOAD_LONG, 8'h32, 8'h00, 8'h00);
		ld(16'h3200, 8'h3c, 4);
		pb(1, OP_ACC_TO_XLOW, 8'h00, 8'h00, 8'h00);
		mx = {mx[15:8], ma};
		step(1, 0);
		pb(1, OP_INDEX_TO_STACK, 8'h00, 8'h00, 8'h00);
		ms = mx - 16'h1;
		step(2, 0);
		pb(1, OP_STACK_TO_INDEX, 8'h00, 8'h00, 8'h00);
		mx = ms + 16'h1;
		step(2, 0);
		pb(3, OP_LOAD_LONG, 8'h32, 8'h01, 8'h00);
		ld(16'h3201, 8'hff, 4);
		pb(1, OP_XLOW_TO_ACC, 8'h00, 8'h00, 8'h00);
		ma = mx[7:0];
		step(1, 0);
		pb(1, OP_ACC_TO_FLAGS, 8'h00, 8'h00, 8'h00);
		mf = ma;
		step(2, 0);
		pb(1, OP_WAIT, 8'h00, 8'h00, 8'h00);
		mf[FLAG_I] = 1'b0;
		step(1, 1);
		repeat (16) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		foreach (q[k]) begin
			repeat (q[k].cyc) @(posedge sys_clk_i);
			if (q[k].wt) begin
				@(negedge sys_clk_i);
				chk(core_clk_run_o, 16'h0);
				chk(mem_rd_o, 16'h0);
				repeat (4) @(posedge sys_clk_i);
				irq_i <= 1'b1;
				@(posedge sys_clk_i);
				irq_i <= 1'b0;
			end
			@(negedge sys_clk_i);
			chk(mem_addr_o, q[k].pc);
			chk(mem_rd_o, 16'h1);
			chk(acc_o, q[k].a);
			chk(index_o, q[k].x);
			chk(stack_o, q[k].s);
			chk(flags_o, q[k].f);
			chk(pc_o, q[k].pc);
			chk(unknown_op_o, q[k].u);
		end
		foreach (wq[k]) chk(mem[wq[k]], mm[wq[k]]);
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge sys_clk_i);
		err_total++;
		print_verdict();
	end
endmodule
